// File: itte_engine.v
// interrupt-triggered transfer engine with apb registers and a main-bus master port
//
// Operation
// - one channel per activating interrupt source, set by CHANNELS
// - normal mode moves one unit per activation
// - repeat mode moves one unit, restores repeat-side address after repeat size
// - repeat size up to 256 units, 1,024 bytes at longword size
// - block mode moves one whole block per activation
// - block length 1 to 256 units
// - unit size byte, word or longword
// - chaining runs several descriptors on one request
// - chain link continues always or only when counter reached zero
// - only one selected sequence trigger source at a time
// - up to 256 sequences for the trigger source
// - first transferred data value selects the sequence
// - sequence runs whole or suspends and resumes on next request
// - short-address mode limits addresses to the two 8 MB halves
// - full-address mode spans the whole 4 GB space
// - cpu interrupt after each unit (each block in block mode) or after the programmed count
// - event link request after each unit, or each block
// - skip descriptor fetch when the same descriptor is reused
// - skip write-back of unchanged fields when address is fixed
// - write-back disable bit suppresses all descriptor write-back
// - displacement register added to source address when the descriptor enables it
// - module stop state halts the engine once its running transfer ends
// - memory reached over a synchronous main bus
//
// The APB interface to the registers and the register addresses were decided locally.
`include "itte_defines.vh"

module itte_engine #(
  parameter CHANNELS = 8,
  parameter CH_W = 3
) (
  input wire clock,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [CHANNELS-1:0] act_req,
  output reg act_ack,
  output reg [CH_W-1:0] act_ack_channel,
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [1:0] mem_size,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack,
  output reg cpu_irq_req,
  output reg [CH_W-1:0] cpu_irq_channel,
  output reg event_link_req,
  output reg [CH_W-1:0] event_link_channel,
  output wire busy
);

  localparam S_IDLE = 3'h0;
  localparam S_FETCH = 3'h1;
  localparam S_RD = 3'h2;
  localparam S_WR = 3'h3;
  localparam S_WB = 3'h4;
  localparam S_NEXT = 3'h5;
  localparam S_IDX = 3'h6;

  reg [2:0] state;
  reg [2:0] operation_reg;
  reg [31:0] desc_base;
  reg [31:0] index_table_base_reg;
  reg [15:0] sequence_enable_reg;
  reg [15:0] address_displacement_reg;
  reg [CH_W-1:0] cur_ch;
  reg [31:0] target;
  reg [31:0] d_addr;
  reg d_valid;
  reg [23:0] d_mode;
  reg [31:0] d_sar;
  reg [31:0] d_dar;
  reg [31:0] d_cnt;
  reg [31:0] data;
  reg [2:0] widx;
  reg cnt_zero;
  reg in_seq;
  reg seq_pick;
  reg first_rd;
  reg [7:0] first_byte;
  reg seq_resume_valid;
  reg [31:0] seq_resume;

  // fixed slave timing: every access completes in its first access cycle
  wire apb_go = psel && penable;
  wire mapped = (paddr == `ITTE_OFS_OPERATION) || (paddr == `ITTE_OFS_DESC_BASE) ||
    (paddr == `ITTE_OFS_INDEX_BASE) || (paddr == `ITTE_OFS_SEQ_ENABLE) ||
    (paddr == `ITTE_OFS_DISPLACE) || (paddr == `ITTE_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = apb_go && !mapped;
  assign busy = (state != S_IDLE);

  wire [1:0] md = d_mode[`ITTE_MA_MODE];
  wire [1:0] sz = d_mode[`ITTE_MA_SIZE];
  wire [1:0] sam = d_mode[`ITTE_MA_SRC_AM];
  wire [1:0] dam = d_mode[`ITTE_MB_DST_AM];
  wire writeback_disable_bit = d_mode[`ITTE_MA_WRITEBACK_DISABLE_BIT];
  wire dst_side = d_mode[`ITTE_MB_DST_SIDE];
  wire stopped = operation_reg[`ITTE_OP_STOP];
  wire [CH_W-1:0] seq_ch = sequence_enable_reg[`ITTE_SEQ_CH_LSB +: CH_W];
  wire seq_en = sequence_enable_reg[`ITTE_SEQ_EN];

  // size codes; the reserved code is treated as longword
  function [1:0] unit_shift;
    input [1:0] s;
    begin
      unit_shift = (s == `ITTE_SIZE_BYTE) ? 2'h0 : ((s == `ITTE_SIZE_WORD) ? 2'h1 : 2'h2);
    end
  endfunction

  function [31:0] step;
    input [31:0] a;
    input [1:0] am;
    input [1:0] s;
    reg [31:0] u;
    begin
      u = 32'h00000001 << unit_shift(s);
      step = am[1] ? (am[0] ? a - u : a + u) : a;
    end
  endfunction

  // rewinds an address that has advanced over n units (n of 0 means 256)
  function [31:0] rewind;
    input [31:0] a;
    input [1:0] am;
    input [1:0] s;
    input [7:0] n;
    reg [31:0] span;
    begin
      span = {23'h0, (n == 8'h00), n} << unit_shift(s);
      rewind = am[1] ? (am[0] ? a + span : a - span) : a;
    end
  endfunction

  // address space mapping on every bus address
  function [31:0] map_addr;
    input [31:0] a;
    input short_mode;
    begin
      map_addr = short_mode ? {{8{a[`ITTE_SHORT_MSB]}}, a[`ITTE_SHORT_MSB:0]} : a;
    end
  endfunction

  function wb_needed;
    input [2:0] w;
    input dis;
    input [1:0] s_am;
    input [1:0] t_am;
    begin
      wb_needed = !dis && ((w == 3'h1 && s_am[1]) || (w == 3'h2 && t_am[1]) || w == 3'h3);
    end
  endfunction

  reg pend_any;
  reg [CH_W-1:0] pend_ch;
  integer i;
  always @* begin
    pend_any = 1'b0;
    pend_ch = {CH_W{1'b0}};
    for (i = CHANNELS - 1; i >= 0; i = i - 1) begin
      if (act_req[i]) begin
        pend_any = 1'b1;
        pend_ch = i[CH_W-1:0];
      end
    end
  end

  // apb read mux, combinational from paddr with no register stage
  always @* begin
    case (paddr)
      `ITTE_OFS_OPERATION: prdata = {29'h0, operation_reg};
      `ITTE_OFS_DESC_BASE: prdata = desc_base;
      `ITTE_OFS_INDEX_BASE: prdata = index_table_base_reg;
      `ITTE_OFS_SEQ_ENABLE: prdata = {16'h0, sequence_enable_reg};
      `ITTE_OFS_DISPLACE: prdata = {16'h0, address_displacement_reg};
      `ITTE_OFS_STATUS: prdata = {15'h0, seq_resume_valid, {(8 - CH_W){1'b0}}, cur_ch,
        4'h0, state, busy};
      default: prdata = 32'h00000000;
    endcase
  end

  wire [31:0] vector_addr = desc_base + {{(28 - CH_W){1'b0}}, pend_ch, 4'h0};
  wire [31:0] disp_ext = {{16{address_displacement_reg[15]}}, address_displacement_reg};
  // displacement shifts the read address only, so sar write-back is unaffected
  wire [31:0] src_eff = d_mode[`ITTE_MC_DISP] ? d_sar + disp_ext : d_sar;
  wire [7:0] unit_next = d_cnt[7:0] - 8'h01;
  wire [15:0] norm_next = d_cnt[15:0] - 16'h0001;
  wire [15:0] blk_next = d_cnt[31:16] - 16'h0001;
  wire [31:0] sar_step = step(d_sar, sam, sz);
  wire [31:0] dar_step = step(d_dar, dam, sz);
  wire bus_done = mem_req && mem_ack;
  wire short_mode = operation_reg[`ITTE_OP_SHORT];

  always @(posedge clock) begin
    if (!reset_n) begin
      state <= S_IDLE;
      operation_reg <= `ITTE_OP_RESET;
      desc_base <= 32'h00000000;
      index_table_base_reg <= 32'h00000000;
      sequence_enable_reg <= 16'h0000;
      address_displacement_reg <= 16'h0000;
      cur_ch <= {CH_W{1'b0}};
      target <= 32'h00000000;
      d_addr <= 32'h00000000;
      d_valid <= 1'b0;
      d_mode <= 24'h000000;
      d_sar <= 32'h00000000;
      d_dar <= 32'h00000000;
      d_cnt <= 32'h00000000;
      data <= 32'h00000000;
      widx <= 3'h0;
      cnt_zero <= 1'b0;
      in_seq <= 1'b0;
      seq_pick <= 1'b0;
      first_rd <= 1'b0;
      first_byte <= 8'h00;
      seq_resume_valid <= 1'b0;
      seq_resume <= 32'h00000000;
      act_ack <= 1'b0;
      act_ack_channel <= {CH_W{1'b0}};
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_size <= 2'h0;
      mem_wdata <= 32'h00000000;
      cpu_irq_req <= 1'b0;
      cpu_irq_channel <= {CH_W{1'b0}};
      event_link_req <= 1'b0;
      event_link_channel <= {CH_W{1'b0}};
    end else begin
      act_ack <= 1'b0;
      cpu_irq_req <= 1'b0;
      event_link_req <= 1'b0;
      if (bus_done) begin
        mem_req <= 1'b0;
      end
      if (apb_go && pwrite) begin
        case (paddr)
          `ITTE_OFS_OPERATION: operation_reg <= pwdata[2:0];
          `ITTE_OFS_DESC_BASE: desc_base <= pwdata;
          `ITTE_OFS_INDEX_BASE: index_table_base_reg <= pwdata;
          // a single trigger channel field; writing it while idle drops any suspended sequence
          `ITTE_OFS_SEQ_ENABLE: sequence_enable_reg <= pwdata[15:0];
          `ITTE_OFS_DISPLACE: address_displacement_reg <= pwdata[15:0];
          default: ;
        endcase
      end
      case (state)
        S_IDLE: begin
          // stop halts new activations; request taken from the controller
          if (pend_any && !stopped) begin
            act_ack <= 1'b1;
            act_ack_channel <= pend_ch;
            cur_ch <= pend_ch;
            first_rd <= 1'b1;
            widx <= 3'h0;
            in_seq <= seq_en && pend_ch == seq_ch;
            seq_pick <= seq_en && pend_ch == seq_ch && !seq_resume_valid;
            // resume a suspended sequence at its stopping point
            if (seq_en && pend_ch == seq_ch && seq_resume_valid) begin
              target <= seq_resume;
            end else begin
              target <= vector_addr;
            end
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          // reuse the loaded descriptor when it is the same one
          if (!mem_req && widx == 3'h0 && operation_reg[`ITTE_OP_RSKIP] && d_valid &&
              d_addr == target) begin
            state <= S_RD;
          end else if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `ITTE_SIZE_LONG;
            mem_addr <= map_addr(target + {27'h0, widx, 2'h0}, short_mode);
          end else if (bus_done) begin
            case (widx)
              3'h0: d_mode <= mem_rdata[23:0];
              3'h1: d_sar <= mem_rdata;
              3'h2: d_dar <= mem_rdata;
              default: d_cnt <= mem_rdata;
            endcase
            if (widx == `ITTE_DESC_WORDS - 3'h1) begin
              widx <= 3'h0;
              d_addr <= target;
              d_valid <= 1'b1;
              state <= S_RD;
            end else begin
              widx <= widx + 3'h1;
            end
          end
        end
        S_RD: begin
          // one unit read of the selected width
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= sz;
            mem_addr <= map_addr(src_eff, short_mode);
          end else if (bus_done) begin
            data <= mem_rdata;
            if (first_rd) begin
              first_byte <= mem_rdata[7:0];
            end
            first_rd <= 1'b0;
            state <= S_WR;
          end
        end
        S_WR: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_size <= sz;
            mem_addr <= map_addr(d_dar, short_mode);
            mem_wdata <= data;
          end else if (bus_done) begin
            // advance both addresses after every unit
            d_sar <= sar_step;
            d_dar <= dar_step;
            state <= S_WB;
            case (md)
              `ITTE_MODE_REPEAT: begin
                // one unit per activation with its event link request
                event_link_req <= 1'b1;
                event_link_channel <= cur_ch;
                // reload counter and rewind repeat-side address
                if (unit_next == 8'h00) begin
                  d_cnt[7:0] <= d_cnt[15:8];
                  cnt_zero <= 1'b1;
                  if (dst_side) begin
                    d_dar <= rewind(dar_step, dam, sz, d_cnt[15:8]);
                  end else begin
                    d_sar <= rewind(sar_step, sam, sz, d_cnt[15:8]);
                  end
                end else begin
                  d_cnt[7:0] <= unit_next;
                  cnt_zero <= 1'b0;
                end
              end
              `ITTE_MODE_BLOCK: begin
                // loop units until the block length is exhausted
                if (unit_next == 8'h00) begin
                  d_cnt[7:0] <= d_cnt[15:8];
                  d_cnt[31:16] <= blk_next;
                  cnt_zero <= blk_next == 16'h0000;
                  // one event link request per whole block
                  event_link_req <= 1'b1;
                  event_link_channel <= cur_ch;
                  if (dst_side) begin
                    d_dar <= rewind(dar_step, dam, sz, d_cnt[15:8]);
                  end else begin
                    d_sar <= rewind(sar_step, sam, sz, d_cnt[15:8]);
                  end
                end else begin
                  d_cnt[7:0] <= unit_next;
                  state <= S_RD;
                end
              end
              default: begin
                // normal mode: one unit, count down
                d_cnt[15:0] <= norm_next;
                cnt_zero <= norm_next == 16'h0000;
                event_link_req <= 1'b1;
                event_link_channel <= cur_ch;
              end
            endcase
          end
        end
        S_WB: begin
          // write back changed words; skip those not needed
          if (!mem_req) begin
            if (widx == `ITTE_DESC_WORDS) begin
              widx <= 3'h0;
              state <= S_NEXT;
            end else if (!wb_needed(widx, writeback_disable_bit, sam, dam)) begin
              widx <= widx + 3'h1;
            end else begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_size <= `ITTE_SIZE_LONG;
              mem_addr <= map_addr(d_addr + {27'h0, widx, 2'h0}, short_mode);
              mem_wdata <= (widx == 3'h1) ? d_sar : ((widx == 3'h2) ? d_dar : d_cnt);
            end
          end else if (bus_done) begin
            widx <= widx + 3'h1;
          end
        end
        S_NEXT: begin
          // cpu interrupt per unit (per block in block mode) or when the count is exhausted
          if (d_mode[`ITTE_MB_IRQ_EACH] || cnt_zero) begin
            cpu_irq_req <= 1'b1;
            cpu_irq_channel <= cur_ch;
          end
          first_rd <= 1'b1;
          if (in_seq && seq_pick && d_mode[`ITTE_MB_INDEX_TABLE_REF_BIT]) begin
            // the first data value indexes the sequence table
            seq_pick <= 1'b0;
            state <= S_IDX;
          end else if (in_seq && d_mode[`ITTE_MB_SEQUENCE_END_BIT]) begin
            seq_resume_valid <= 1'b0;
            state <= S_IDLE;
          end else if (d_mode[`ITTE_MB_CHAIN] && (!d_mode[`ITTE_MB_CHAIN_ZERO] || cnt_zero)) begin
            target <= d_addr + `ITTE_DESC_STRIDE;
            state <= S_FETCH;
          end else if (in_seq && !seq_pick) begin
            // sequence division: park the next descriptor for the next request
            seq_resume <= d_addr + `ITTE_DESC_STRIDE;
            seq_resume_valid <= 1'b1;
            state <= S_IDLE;
          end else begin
            state <= S_IDLE;
          end
        end
        S_IDX: begin
          // 256 longword entries, one per sequence
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_size <= `ITTE_SIZE_LONG;
            mem_addr <= map_addr(index_table_base_reg + {22'h0, first_byte, 2'h0}, short_mode);
          end else if (bus_done) begin
            target <= mem_rdata;
            state <= S_FETCH;
          end
        end
        default: state <= S_IDLE;
      endcase
      // software changes to descriptor location invalidate the reuse shortcut
      if (apb_go && pwrite && (paddr == `ITTE_OFS_DESC_BASE || paddr == `ITTE_OFS_SEQ_ENABLE)) begin
        d_valid <= 1'b0;
        if (paddr == `ITTE_OFS_SEQ_ENABLE && state == S_IDLE) begin
          seq_resume_valid <= 1'b0;
        end
      end
    end
  end

endmodule // itte_engine

// File: itte_defines.vh
// register offsets, descriptor field positions and mode and size codes of the transfer engine
`ifndef ITTE_DEFINES_VH
`define ITTE_DEFINES_VH

// apb register byte offsets
`define ITTE_OFS_OPERATION 12'h000
`define ITTE_OFS_DESC_BASE 12'h004
`define ITTE_OFS_INDEX_BASE 12'h008
`define ITTE_OFS_SEQ_ENABLE 12'h00c
`define ITTE_OFS_DISPLACE 12'h010
`define ITTE_OFS_STATUS 12'h014

// operation_reg bits and reset value
`define ITTE_OP_STOP 0
`define ITTE_OP_SHORT 1
`define ITTE_OP_RSKIP 2
`define ITTE_OP_RESET 3'h0

// sequence_enable_reg fields
`define ITTE_SEQ_EN 0
`define ITTE_SEQ_CH_LSB 8

// descriptor layout: four words, 16 bytes per descriptor
`define ITTE_DESC_WORDS 3'h4
`define ITTE_DESC_STRIDE 32'h00000010
// word 0: transfer_mode_word_a [7:0], transfer_mode_word_b [15:8], transfer_mode_word_c [23:16]
`define ITTE_MA_MODE 7:6
`define ITTE_MA_SIZE 5:4
`define ITTE_MA_SRC_AM 3:2
`define ITTE_MA_WRITEBACK_DISABLE_BIT 0
`define ITTE_MB_CHAIN 15
`define ITTE_MB_CHAIN_ZERO 14
`define ITTE_MB_IRQ_EACH 13
`define ITTE_MB_DST_SIDE 12
`define ITTE_MB_DST_AM 11:10
`define ITTE_MB_SEQUENCE_END_BIT 9
`define ITTE_MB_INDEX_TABLE_REF_BIT 8
`define ITTE_MC_DISP 16
// word 3: normal count [15:0]; repeat/block unit count [7:0], reload [15:8], blocks [31:16]

// transfer modes and unit sizes
`define ITTE_MODE_NORMAL 2'h0
`define ITTE_MODE_REPEAT 2'h1
`define ITTE_MODE_BLOCK 2'h2
`define ITTE_SIZE_BYTE 2'h0
`define ITTE_SIZE_WORD 2'h1
`define ITTE_SIZE_LONG 2'h2

// short-address mode keeps 24 address bits and sign-extends bit 23
`define ITTE_SHORT_MSB 23

`endif

// File: itte_props.sv
// concurrent checks on the transfer engine ports
module itte_props #(
  parameter CHANNELS = 8,
  parameter CH_W = 3
) (
  input wire clock,
  input wire reset_n,
  input wire [CHANNELS-1:0] act_req,
  input wire act_ack,
  input wire [CH_W-1:0] act_ack_channel,
  input wire busy,
  input wire mem_req,
  input wire mem_ack,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [1:0] mem_size,
  input wire [31:0] mem_wdata,
  input wire event_link_req,
  input wire cpu_irq_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  // taken channel was requesting and no lower channel was
  property p_ack_cause;
    act_ack |-> ((($past(act_req) >> act_ack_channel) & 1) != 0)
      && (($past(act_req) & ((1 << act_ack_channel) - 1)) == 0);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without matching request");
  property p_ack_idle;
    act_ack |-> busy && !$past(busy);
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("activation taken while busy");
  property p_ack_pulse;
    act_ack |=> !act_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_size) && $stable(mem_wdata);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("bus request changed before ack");
  property p_mem_drop;
    mem_req && mem_ack |=> !mem_req;
  endproperty
  a_mem_drop: assert property (p_mem_drop) else $error("bus request kept after ack");
  property p_unit_size;
    mem_req |-> mem_size != 2'h3;
  endproperty
  a_unit_size: assert property (p_unit_size) else $error("illegal unit size");
  property p_idle_bus;
    !busy |-> !mem_req;
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("bus access while idle");
  property p_evt_pulse;
    event_link_req |-> $past(busy) ##1 !event_link_req;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse) else $error("bad event link pulse");
  property p_irq_pulse;
    cpu_irq_req |=> !cpu_irq_req;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("cpu request longer than a cycle");

  c_take: cover property (act_ack);
  c_event: cover property (event_link_req);
  c_slow: cover property (mem_req && !mem_ack ##1 mem_req && !mem_ack);
endmodule // itte_props

bind itte_engine itte_props #(.CHANNELS(CHANNELS), .CH_W(CH_W)) i_props (
  .clock(clock), .reset_n(reset_n), .act_req(act_req), .act_ack(act_ack),
  .act_ack_channel(act_ack_channel), .busy(busy), .mem_req(mem_req), .mem_ack(mem_ack),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
  .event_link_req(event_link_req), .cpu_irq_req(cpu_irq_req));

// File: itte_mem_model.sv
// behavioural main-bus memory answering the transfer engine
module itte_mem_model (
  input wire clock,
  input wire reset_n,
  input wire slow,
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [1:0] mem_size,
  input wire [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [0:1023];
  logic [2:0] wait_cnt;

  // read at the ack edge, so words the bench puts into the array are always seen
  function automatic logic [31:0] rd_at(input logic [9:0] a, input logic [1:0] sz);
    rd_at = 32'h0;
    for (int i = 0; i < 4; i++) if (i < (1 << sz)) rd_at[8*i +: 8] = m[a + i];
  endfunction

  always @(posedge clock) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      wait_cnt <= 3'h0;
      mem_rdata <= 32'h0;
    end else begin
      mem_ack <= 1'b0;
      // data outside an ack cycle is inverted every cycle, so it equals the last value every second cycle
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_cnt == (slow ? 3'h3 : 3'h0)) begin
          mem_ack <= 1'b1;
          wait_cnt <= 3'h0;
          if (!mem_we) mem_rdata <= rd_at(mem_addr[9:0], mem_size);
          else for (int i = 0; i < 4; i++)
            if (i < (1 << mem_size)) m[mem_addr[9:0] + i] <= mem_wdata[8*i +: 8];
        end else wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule // itte_mem_model

// File: itte_tb.sv
// self-checking bench for the transfer engine
`include "itte_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, ev;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, mem_addr, mem_wdata, mem_rdata, rv, exp, s, d;
  logic [7:0] act_req = 0;
  logic pready, pslverr, act_ack, mem_req, mem_we, mem_ack, cpu_irq_req, event_link_req, busy;
  logic [2:0] act_ack_channel, cpu_irq_channel, event_link_channel;
  logic [1:0] mem_size;
  int mismatches = 0, n_checks = 0, cycles = 0, n_evt = 0, n_irq = 0, e0, i0;

  always #12.5 clock = ~clock;

  itte_engine i_dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .act_req(act_req), .act_ack(act_ack), .act_ack_channel(act_ack_channel),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_channel(cpu_irq_channel), .event_link_req(event_link_req),
    .event_link_channel(event_link_channel), .busy(busy));
  itte_mem_model i_mem (.clock(clock), .reset_n(reset_n), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end

  task end_sim;
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (event_link_req === 1'b1) n_evt <= n_evt + 1;
    if (cpu_irq_req === 1'b1) n_irq <= n_irq + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim;
    end
  end

  task apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] rd32(input int a);
    return {i_mem.m[a+3], i_mem.m[a+2], i_mem.m[a+1], i_mem.m[a]};
  endfunction

  task wr32(input int a, input logic [31:0] v);
    {i_mem.m[a+3], i_mem.m[a+2], i_mem.m[a+1], i_mem.m[a]} = v;
  endtask

  task wait_done(input int ch);
    @(posedge clock);
    while (act_ack !== 1'b1) @(posedge clock);
    `CHK(act_ack_channel, 3'(ch))
    act_req[ch] <= 1'b0;
    while (busy !== 1'b0) @(posedge clock);
    repeat (2) @(posedge clock);
  endtask

  task activate(input int ch);
    @(posedge clock);
    act_req[ch] <= 1'b1;
    wait_done(ch);
  endtask

  // descriptor of channel ch at base 0x100, cleared target, then one activation
  task run(input int ch, input logic [31:0] w0, sa, da, w3);
    wr32(256 + 16 * ch, w0);
    wr32(260 + 16 * ch, sa);
    wr32(264 + 16 * ch, da);
    wr32(268 + 16 * ch, w3);
    wr32(da, 32'h0);
    e0 = n_evt;
    i0 = n_irq;
    activate(ch);
  endtask

  initial begin
    for (int i = 0; i < 1024; i++) i_mem.m[i] = 8'(i) ^ 8'h5c;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    apb(`ITTE_OFS_OPERATION, 0, 0);
    `CHK(rv, 32'h0)
    apb(12'h020, 0, 0);
    `CHK(ev, 1'b1)
    `CHK(rv, 32'h0)
    apb(`ITTE_OFS_STATUS, 1, 32'hffff);
    apb(`ITTE_OFS_STATUS, 0, 0);
    `CHK(rv, 32'h0)
    apb(`ITTE_OFS_DESC_BASE, 1, 32'h100);
    apb(`ITTE_OFS_DISPLACE, 1, 32'h20);
    apb(`ITTE_OFS_DISPLACE, 0, 0);
    `CHK(rv[15:0], 16'h0020)
    // byte, word and longword; the longword pass also reads through the displacement
    for (int k = 0; k < 3; k++) begin
      s = 32'h200 + 16 * k;
      d = 32'h300 + 16 * k;
      exp = rd32(k == 2 ? s + 32'h20 : s) & ~(32'hffffffff << (8 << k));
      run(k, 32'h0808 | (k << 4) | (k == 2 ? 32'h10000 : 32'h0), s, d, 32'h1);
      `CHK(rd32(d), exp)
      `CHK(rd32(260 + 16 * k), s + (1 << k))
      `CHK(rd32(264 + 16 * k), d + (1 << k))
      `CHK(rd32(268 + 16 * k), 32'h0)
      `CHK(n_evt - e0, 1)
      `CHK(n_irq - i0, 1)
    end
    slow <= 1'b1;
    exp = rd32(32'h281) & 32'hff;
    run(3, 32'h2048, 32'h280, 32'h380, 32'h0202);
    activate(3);
    `CHK(rd32(32'h380), exp)
    `CHK(rd32(32'h134), 32'h280)
    `CHK(rd32(32'h13c) & 32'hff, 32'h2)
    `CHK(rd32(32'h138), 32'h380)
    `CHK(n_evt - e0, 2)
    `CHK(n_irq - i0, 2)
    exp = rd32(32'h2c0);
    run(4, 32'h0888, 32'h2c0, 32'h3c0, 32'h00010404);
    `CHK(rd32(32'h3c0), exp)
    `CHK(rd32(32'h148), 32'h3c4)
    `CHK(n_evt - e0, 1)
    slow <= 1'b0;
    wr32(32'h160, 32'h0);
    wr32(32'h164, 32'h2f0);
    wr32(32'h168, 32'h3f0);
    wr32(32'h16c, 32'h1);
    wr32(32'h3f0, 32'h0);
    exp = rd32(32'h2e0) & 32'hff;
    run(5, 32'hc809, 32'h2e0, 32'h3e0, 32'h1);
    `CHK(rd32(32'h3e0), exp)
    `CHK(rd32(32'h3f0), rd32(32'h2f0) & 32'hff)
    `CHK(rd32(32'h154), 32'h2e0)
    `CHK(rd32(32'h16c), 32'h0)
    // stopped engine leaves a pending request waiting
    wr32(32'h170, 32'h0);
    wr32(32'h174, 32'h2f8);
    wr32(32'h178, 32'h3f8);
    wr32(32'h17c, 32'h1);
    wr32(32'h3f8, 32'h0);
    apb(`ITTE_OFS_OPERATION, 1, 32'h1);
    act_req[7] <= 1'b1;
    repeat (20) @(posedge clock);
    `CHK(busy, 1'b0)
    `CHK(rd32(32'h3f8), 32'h0)
    apb(`ITTE_OFS_OPERATION, 1, 32'h0);
    wait_done(7);
    `CHK(rd32(32'h3f8), rd32(32'h2f8) & 32'hff)
    // reused descriptor: a source address word changed in memory must go unread
    wr32(32'h174, 32'h2fa);
    wr32(32'h3f8, 32'h0);
    apb(`ITTE_OFS_OPERATION, 1, 32'h4);
    activate(7);
    `CHK(rd32(32'h3f8), rd32(32'h2f8) & 32'hff)
    `CHK(rd32(32'h17c), 32'hffff)
    end_sim;
  end
endmodule // testbench
